// ===== hw/eeprom_spi_pkg.sv
package eeprom_spi_pkg;

    // ==========================================================
    // Opcodes, shifted in most significant bit first.
    // ==========================================================
    localparam logic [7:0] LATCH_SET_CMD    = 8'h06;
    localparam logic [7:0] LATCH_CLEAR_CMD  = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] MEM_READ_CMD     = 8'h03;
    localparam logic [7:0] MEM_WRITE_CMD    = 8'h02;

    // ==========================================================
    // Status register field positions and reset values.
    // ==========================================================
    localparam int unsigned STATUS_WRITE_DISABLE_BIT = 7;
    localparam int unsigned BLOCK_PROTECT_HI_BIT     = 3;
    localparam int unsigned BLOCK_PROTECT_LO_BIT     = 2;
    localparam int unsigned WRITE_ENABLE_LATCH_BIT   = 1;
    localparam int unsigned CYCLE_IN_PROGRESS_BIT    = 0;
    localparam logic        STATUS_WRITE_DISABLE_RST = 1'b0;
    localparam logic [1:0]  BLOCK_PROTECT_RST        = 2'h0;

    // ==========================================================
    // Byte framing and timing.
    // ==========================================================
    localparam logic [2:0]  LAST_BIT_IDX     = 3'h7;
    localparam logic [1:0]  MEM_WRITE_BYTES  = 2'h3;
    localparam int unsigned CLK_FREQ_KHZ     = 50000;
    localparam int unsigned WRITE_TIME_US    = 5000;
    localparam int unsigned WRITE_CYCLES     =
        (WRITE_TIME_US * CLK_FREQ_KHZ) / 1000;

endpackage : eeprom_spi_pkg

// ===== hw/spi_eeprom_command_status_unit.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Serial output changes only after a sampled falling clock edge.
// - Serial input is captured on each sampled rising clock edge.
// - Chip select high deselects, output released; standby unless busy.
// - Traffic ignored after reset until a chip select falling edge.
// - Hold pauses the link while selected: output off, clock ignored.
// - Opcode byte first; 06h sets latch, 04h clears latch.
// - Status read 05h accepted anytime, status repeats while selected.
// - Opcode 03h is decoded as memory array read.
// - Opcode 02h is decoded as memory array write.
// - Unknown opcode: ignore everything until chip select rises.
// - Memory and status writes refused while the latch is clear.
// - After latch set or clear opcode, wait for chip select high.
// - Latch cleared by reset, clear command, and write cycle completion.
// - In-progress flag is one exactly while a write cycle runs.
// - Block-protect bits change only by status write, not when protected.
// - Disable bit set and write-protect low refuses status writes.
// - Status write ignores bits 6,5,4,1,0; bits 6..4 read zero.
// - Status write runs only if select rises right after eighth bit.
// - Select rise after valid status write starts timed cycle.
// - Old protect values hold during the cycle, new ones at completion.
module spi_eeprom_command_status_unit #(
    parameter int unsigned WRITE_CYCLES = eeprom_spi_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    // Serial pins, asynchronous to sys_clk_i
    input  wire logic       spi_clk_i,
    input  wire logic       spi_cs_b_i,
    input  wire logic       spi_data_i,
    input  wire logic       spi_hold_b_i,
    input  wire logic       write_protect_b_i,
    output logic            spi_data_o,
    output logic            spi_data_oe_o,
    // Memory array side
    output logic            mem_read_cmd_o,
    output logic            mem_write_start_o,
    // Status view
    output logic [1:0]      block_protect_o,
    output logic            hardware_protected_mode_o,
    output logic            write_enable_latch_o,
    output logic            cycle_in_progress_o
);

    // ==========================================================
    // State.
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE        = 3'b000,
        ST_OPCODE      = 3'b001,
        ST_WAIT        = 3'b010,
        ST_STATUS_OUT  = 3'b011,
        ST_STATUS_DATA = 3'b100,
        ST_MEM_READ    = 3'b101,
        ST_MEM_WRITE   = 3'b110,
        ST_IGNORE      = 3'b111
    } link_state_type;
    typedef struct packed {
        logic [2:0]     clk_sync;
        logic [2:0]     cs_sync;
        logic [1:0]     data_sync;
        logic [1:0]     hold_sync;
        logic [1:0]     wp_sync;
        link_state_type st;
        logic           armed;
        logic [2:0]     bit_cnt;
        logic [7:0]     shift;
        logic [7:0]     opcode;
        logic           sr_ready;
        logic [1:0]     wr_bytes;
        logic [2:0]     out_idx;
        logic           out_started;
        logic           data_out;
        logic           data_oe;
        logic           write_enable_latch;
        logic           status_write_disable;
        logic [1:0]     bp;
        logic           pend_status_write_disable;
        logic [1:0]     pend_bp;
        logic           pend_status;
        logic           hardware_protected_mode;
        logic           mem_rd;
        logic           start;
        logic           mem_wr;
    } unit_state_type;

    unit_state_type r;
    unit_state_type next_r;
    logic timer_busy;
    logic timer_done;

    // ==========================================================
    // Self-timed write cycle.
    // ==========================================================
    write_cycle_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .start_i   (r.start),
        .busy_o    (timer_busy),
        .done_o    (timer_done)
    );

    // ==========================================================
    // Next-state logic.
    // ==========================================================
    always_comb
    begin
        logic       clk_rise;
        logic       clk_fall;
        logic       cs_rise;
        logic       cs_fall;
        logic       selected;
        logic       held;
        logic       busy;
        logic [7:0] byte_in;
        logic [7:0] status;

        next_r = r;
        next_r.mem_rd = 1'b0;
        next_r.start  = 1'b0;
        next_r.mem_wr = 1'b0;

        // Select chain resets low, so only a real high-to-low arms the link.
        next_r.clk_sync  = {r.clk_sync[1:0], spi_clk_i};
        next_r.cs_sync   = {r.cs_sync[1:0], spi_cs_b_i};
        next_r.data_sync = {r.data_sync[0], spi_data_i};
        next_r.hold_sync = {r.hold_sync[0], spi_hold_b_i};
        next_r.wp_sync   = {r.wp_sync[0], write_protect_b_i};

        clk_rise = r.clk_sync[1] & ~r.clk_sync[2];
        clk_fall = ~r.clk_sync[1] & r.clk_sync[2];
        cs_rise  = r.cs_sync[1] & ~r.cs_sync[2];
        cs_fall  = ~r.cs_sync[1] & r.cs_sync[2];
        selected = ~r.cs_sync[1];
        held     = selected & ~r.hold_sync[1];
        busy     = timer_busy;
        byte_in  = {r.shift[6:0], r.data_sync[1]};

        status = 8'h00;
        status[eeprom_spi_pkg::STATUS_WRITE_DISABLE_BIT] = r.status_write_disable;
        status[eeprom_spi_pkg::BLOCK_PROTECT_HI_BIT]     = r.bp[1];
        status[eeprom_spi_pkg::BLOCK_PROTECT_LO_BIT]     = r.bp[0];
        status[eeprom_spi_pkg::WRITE_ENABLE_LATCH_BIT]   = r.write_enable_latch;
        status[eeprom_spi_pkg::CYCLE_IN_PROGRESS_BIT]    = busy;

        next_r.hardware_protected_mode = r.status_write_disable & ~r.wp_sync[1];

        if (cs_fall)
        begin
            next_r.armed       = 1'b1;
            next_r.st          = ST_OPCODE;
            next_r.bit_cnt     = 3'h0;
            next_r.out_idx     = 3'h0;
            next_r.out_started = 1'b0;
            next_r.sr_ready    = 1'b0;
            next_r.wr_bytes    = 2'h0;
        end
        else if (cs_rise)
        begin
            case (r.st)
                ST_WAIT:
                begin
                    next_r.write_enable_latch =
                        r.opcode == eeprom_spi_pkg::LATCH_SET_CMD;
                end
                ST_STATUS_DATA:
                begin
                    if (r.sr_ready && r.write_enable_latch && !r.hardware_protected_mode && !busy)
                    begin
                        next_r.start       = 1'b1;
                        next_r.pend_status = 1'b1;
                        next_r.pend_status_write_disable   =
                            r.shift[eeprom_spi_pkg::STATUS_WRITE_DISABLE_BIT];
                        next_r.pend_bp     = {
                            r.shift[eeprom_spi_pkg::BLOCK_PROTECT_HI_BIT],
                            r.shift[eeprom_spi_pkg::BLOCK_PROTECT_LO_BIT]};
                    end
                end
                ST_MEM_WRITE:
                begin
                    if (r.bit_cnt == 3'h0 && r.write_enable_latch && !busy &&
                        r.wr_bytes == eeprom_spi_pkg::MEM_WRITE_BYTES)
                    begin
                        next_r.start  = 1'b1;
                        next_r.mem_wr = 1'b1;
                    end
                end
                default:
                begin
                    next_r.st = ST_IDLE;
                end
            endcase
            next_r.st = ST_IDLE;
        end
        else if (selected && r.armed && !held)
        begin
            if (clk_rise && r.st != ST_IGNORE && r.st != ST_IDLE)
            begin
                next_r.shift   = byte_in;
                next_r.bit_cnt = r.bit_cnt + 3'h1;
                case (r.st)
                    ST_OPCODE:
                    begin
                        if (r.bit_cnt == eeprom_spi_pkg::LAST_BIT_IDX)
                        begin
                            next_r.opcode = byte_in;
                            if (byte_in == eeprom_spi_pkg::STATUS_READ_CMD)
                            begin
                                next_r.st = ST_STATUS_OUT;
                            end
                            else if (busy)
                            begin
                                next_r.st = ST_IGNORE;
                            end
                            else
                            begin
                                case (byte_in)
                                    eeprom_spi_pkg::LATCH_SET_CMD,
                                    eeprom_spi_pkg::LATCH_CLEAR_CMD:
                                    begin
                                        next_r.st = ST_WAIT;
                                    end
                                    eeprom_spi_pkg::STATUS_WRITE_CMD:
                                    begin
                                        next_r.st = ST_STATUS_DATA;
                                    end
                                    eeprom_spi_pkg::MEM_READ_CMD:
                                    begin
                                        next_r.st     = ST_MEM_READ;
                                        next_r.mem_rd = 1'b1;
                                    end
                                    eeprom_spi_pkg::MEM_WRITE_CMD:
                                    begin
                                        next_r.st = ST_MEM_WRITE;
                                    end
                                    default:
                                    begin
                                        next_r.st = ST_IGNORE;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_STATUS_DATA:
                    begin
                        if (r.sr_ready)
                        begin
                            next_r.sr_ready = 1'b0;
                            next_r.st       = ST_IGNORE;
                        end
                        else if (r.bit_cnt == eeprom_spi_pkg::LAST_BIT_IDX)
                        begin
                            next_r.sr_ready = 1'b1;
                        end
                    end
                    ST_MEM_WRITE:
                    begin
                        if (r.bit_cnt == eeprom_spi_pkg::LAST_BIT_IDX &&
                            r.wr_bytes != eeprom_spi_pkg::MEM_WRITE_BYTES)
                        begin
                            next_r.wr_bytes = r.wr_bytes + 2'h1;
                        end
                    end
                    default:
                    begin
                        next_r.st = r.st;
                    end
                endcase
            end
            if (clk_fall && r.st == ST_STATUS_OUT)
            begin
                next_r.data_out    = status[3'h7 - r.out_idx];
                next_r.out_idx     = r.out_idx + 3'h1;
                next_r.out_started = 1'b1;
            end
        end

        // Output released when deselected, held or not reading status.
        next_r.data_oe = selected && !held && r.armed &&
                         next_r.st == ST_STATUS_OUT && next_r.out_started;

        // A completion takes effect after any latch command of the cycle.
        if (timer_done)
        begin
            next_r.write_enable_latch = 1'b0;
            if (r.pend_status)
            begin
                next_r.status_write_disable = r.pend_status_write_disable;
                next_r.bp   = r.pend_bp;
            end
            next_r.pend_status = 1'b0;
        end
    end

    // ==========================================================
    // Registers.
    // ==========================================================
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r          <= '0;
            r.clk_sync <= 3'h7;
            r.hold_sync <= 2'h3;
            r.wp_sync  <= 2'h3;
            r.status_write_disable     <= eeprom_spi_pkg::STATUS_WRITE_DISABLE_RST;
            r.bp       <= eeprom_spi_pkg::BLOCK_PROTECT_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs.
    // ==========================================================
    assign spi_data_o                = r.data_out;
    assign spi_data_oe_o             = r.data_oe;
    assign mem_read_cmd_o            = r.mem_rd;
    assign mem_write_start_o         = r.mem_wr;
    assign block_protect_o           = r.bp;
    assign hardware_protected_mode_o = r.hardware_protected_mode;
    assign write_enable_latch_o      = r.write_enable_latch;
    assign cycle_in_progress_o       = timer_busy;

endmodule : spi_eeprom_command_status_unit

`default_nettype wire

// ===== hw/write_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none

module write_cycle_timer #(
    parameter int unsigned CYCLES = eeprom_spi_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    // Control
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    localparam int unsigned CW = $clog2(CYCLES + 1);

    initial
    begin
        if (CYCLES < 1)
        begin
            $error("write_cycle_timer: CYCLES must be at least 1");
        end
    end

    typedef struct packed {
        logic          busy;
        logic          done;
        logic [CW-1:0] count;
    } timer_state_type;

    timer_state_type r;
    timer_state_type next_r;

    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        if (r.busy)
        begin
            if (r.count == CW'(1))
            begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end
            next_r.count = r.count - CW'(1);
        end
        else if (start_i)
        begin
            next_r.busy  = 1'b1;
            next_r.count = CW'(CYCLES);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign busy_o = r.busy;
    assign done_o = r.done;

endmodule : write_cycle_timer

`default_nettype wire

// ===== test/spi_eeprom_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port-level checks of the serial status unit.
// ==========================================================
module spi_eeprom_status_monitor #(
    parameter int unsigned WRITE_CYCLES = 50
) (
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       rst_b_i,
    // Serial pins
    input wire logic       spi_clk_i,
    input wire logic       spi_cs_b_i,
    input wire logic       spi_data_i,
    input wire logic       spi_hold_b_i,
    input wire logic       write_protect_b_i,
    input wire logic       spi_data_o,
    input wire logic       spi_data_oe_o,
    // Array side and status view
    input wire logic       mem_read_cmd_o,
    input wire logic       mem_write_start_o,
    input wire logic [1:0] block_protect_o,
    input wire logic       hardware_protected_mode_o,
    input wire logic       write_enable_latch_o,
    input wire logic       cycle_in_progress_o
);
    int unsigned busy_len;
    logic [3:0]  since_done;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    // Counters let long spans be judged without huge repetitions.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_len   <= 0;
            since_done <= 4'hf;
        end
        else
        begin
            busy_len   <= cycle_in_progress_o ? busy_len + 1 : 0;
            since_done <= cycle_in_progress_o ? 4'h0 :
                since_done + {3'h0, since_done != 4'hf};
        end
    end

    chk_oe_deselect: assert property (
        spi_cs_b_i [*6] |-> !spi_data_oe_o)
        else $error("output enabled while deselected");
    chk_oe_hold: assert property (
        !spi_hold_b_i [*6] |-> !spi_data_oe_o)
        else $error("output enabled while held");
    chk_hpm_pin: assert property (
        write_protect_b_i [*6] |-> !hardware_protected_mode_o)
        else $error("protected mode with write protect high");
    chk_bp_frozen: assert property (
        cycle_in_progress_o && $past(cycle_in_progress_o)
        |-> $stable(block_protect_o))
        else $error("protect bits moved during cycle");
    chk_bp_at_done: assert property (
        $changed(block_protect_o) |-> since_done <= 4'h3)
        else $error("protect bits moved outside a status write");
    chk_wel_done: assert property (
        $fell(cycle_in_progress_o) |-> ##[0:3] !write_enable_latch_o)
        else $error("latch kept after cycle end");
    chk_busy_len: assert property (
        $fell(cycle_in_progress_o)
        |-> busy_len >= WRITE_CYCLES - 2 && busy_len <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    chk_wel_at_cs: assert property (
        $rose(write_enable_latch_o) |-> spi_cs_b_i)
        else $error("latch set while selected");
    chk_wr_needs_wel: assert property (
        $rose(cycle_in_progress_o) |-> write_enable_latch_o)
        else $error("write cycle without latch");
    chk_rd_pulse: assert property (
        mem_read_cmd_o |-> !spi_cs_b_i ##1 !mem_read_cmd_o)
        else $error("read decode pulse wrong");

    cover property ($fell(cycle_in_progress_o));
    cover property (mem_read_cmd_o);
    cover property ($rose(hardware_protected_mode_o));
endmodule : spi_eeprom_status_monitor

bind spi_eeprom_command_status_unit spi_eeprom_status_monitor #(
    .WRITE_CYCLES(WRITE_CYCLES)
) u_mon (.*);

`default_nettype wire

// ===== test/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Mode 0 master: clock idles low and stands still between frames.
// ==========================================================
module spi_master_model (
    // Pins toward the device
    output logic      spi_clk_o,
    output logic      spi_cs_b_o,
    output logic      spi_data_o,
    output logic      spi_hold_b_o,
    input  wire logic spi_q_i,
    input  wire logic spi_q_oe_i
);
    localparam time HALF = 80ns;

    // Select starts low, so the first frame after reset lacks a fall.
    initial
    begin
        spi_clk_o    = 1'b0;
        spi_cs_b_o   = 1'b0;
        spi_data_o   = 1'b0;
        spi_hold_b_o = 1'b1;
    end

    task automatic select();
        spi_cs_b_o = 1'b0;
        #(HALF);
    endtask : select

    // Sampling late in the high phase gives the synchronised output time.
    task automatic shift(input logic [7:0] v, input int n,
                         output logic [7:0] q);
        q = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            spi_data_o = v[i];
            #(HALF) spi_clk_o = 1'b1;
            #(HALF - 10ns) q = {q[6:0], spi_q_oe_i ? spi_q_i : 1'bx};
            #10ns spi_clk_o = 1'b0;
        end
    endtask : shift

    // Clock pulses during the pause must be ignored by the device.
    // Hold waits a half period after the last fall so that edge still counts.
    task automatic pause(output logic oe_seen);
        #(HALF);
        spi_hold_b_o = 1'b0;
        repeat (2)
        begin
            #(HALF) spi_clk_o = 1'b1;
            #(HALF) spi_clk_o = 1'b0;
            spi_data_o = ~spi_data_o;
        end
        oe_seen = spi_q_oe_i;
        #(HALF) spi_hold_b_o = 1'b1;
        #(HALF);
    endtask : pause

    // Released data line shows the inverse, never a stale value.
    task automatic deselect();
        #(HALF) spi_cs_b_o = 1'b1;
        spi_data_o = ~spi_data_o;
        #(4 * HALF);
    endtask : deselect
endmodule : spi_master_model

`default_nettype wire

// ===== test/test_spi_eeprom_command_status_unit.sv
`timescale 1ns/1ps
`default_nettype none

module test_spi_eeprom_command_status_unit;
    localparam int unsigned CYC = 400;
    logic       sys_clk_i;
    logic       rst_b_i;
    logic       wp_b;
    wire logic  sck, cs_b, mosi, hold_b;
    logic       q, q_oe, rd_p, wr_p, hardware_protected_mode, write_enable_latch, busy;
    logic [1:0] bp;
    logic [7:0] st, s2;
    logic       oe_h;
    int         err_total = 0;
    int         n_tests = 0;
    int         rd_cnt = 0;
    int         wr_cnt = 0;

    spi_eeprom_command_status_unit #(.WRITE_CYCLES(CYC)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .spi_clk_i(sck),
        .spi_cs_b_i(cs_b), .spi_data_i(mosi), .spi_hold_b_i(hold_b),
        .write_protect_b_i(wp_b), .spi_data_o(q), .spi_data_oe_o(q_oe),
        .mem_read_cmd_o(rd_p), .mem_write_start_o(wr_p),
        .block_protect_o(bp), .hardware_protected_mode_o(hardware_protected_mode),
        .write_enable_latch_o(write_enable_latch), .cycle_in_progress_o(busy));

    spi_master_model u_master (
        .spi_clk_o(sck), .spi_cs_b_o(cs_b), .spi_data_o(mosi),
        .spi_hold_b_o(hold_b), .spi_q_i(q), .spi_q_oe_i(q_oe));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i)
    begin
        rd_cnt <= rd_cnt + int'(rd_p === 1'b1);
        wr_cnt <= wr_cnt + int'(wr_p === 1'b1);
    end

    // ==========================================================
    // Access tasks
    // ==========================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cmd(input logic [7:0] op, input logic [7:0] d,
                       input int n);
        logic [7:0] q8;
        u_master.select();
        u_master.shift(op, 8, q8);
        if (n > 0)
            u_master.shift(d, n, q8);
        u_master.deselect();
    endtask : cmd

    task automatic rd_status(output logic [7:0] s);
        logic [7:0] q8;
        u_master.select();
        u_master.shift(eeprom_spi_pkg::STATUS_READ_CMD, 8, q8);
        u_master.shift(8'h00, 8, s);
        u_master.deselect();
        check({7'h00, q_oe}, 8'h00);
    endtask : rd_status

    // Polls like a careful host instead of waiting a fixed time.
    task automatic wait_idle();
        logic [7:0] s;
        int         k;
        k = 0;
        do
            rd_status(s);
        while (s[0] !== 1'b0 && ++k < 20);
        check({7'h00, s[0]}, 8'h00);
    endtask : wait_idle

    task automatic mem_write();
        logic [7:0] q8;
        u_master.select();
        u_master.shift(eeprom_spi_pkg::MEM_WRITE_CMD, 8, q8);
        repeat (3) u_master.shift(8'h5a, 8, q8);
        u_master.deselect();
    endtask : mem_write

    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    initial
    begin
        #1ms;
        err_total++;
        close_out();
    end

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial
    begin
        rst_b_i = 1'b0;
        wp_b    = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #2 rst_b_i = 1'b1;
        cmd(eeprom_spi_pkg::LATCH_SET_CMD, 8'h00, 0);
        check({7'h00, write_enable_latch}, 8'h00);
        rd_status(st);
        check(st, 8'h00);
        cmd(eeprom_spi_pkg::LATCH_SET_CMD, 8'hff, 8);
        check({7'h00, write_enable_latch}, 8'h01);
        cmd(eeprom_spi_pkg::LATCH_CLEAR_CMD, 8'hff, 8);
        check({7'h00, write_enable_latch}, 8'h00);
        cmd(eeprom_spi_pkg::STATUS_WRITE_CMD, 8'hff, 8);
        rd_status(st);
        check(st, 8'h00);
        cmd(eeprom_spi_pkg::LATCH_SET_CMD, 8'h00, 0);
        cmd(eeprom_spi_pkg::STATUS_WRITE_CMD, 8'hff, 8);
        rd_status(st);
        check(st, 8'h03);
        check({6'h00, bp}, 8'h00);
        wait_idle();
        rd_status(st);
        check(st, 8'h8c);
        check({6'h00, bp}, 8'h03);
        @(posedge sys_clk_i);
        #2 wp_b = 1'b0;
        cmd(eeprom_spi_pkg::LATCH_SET_CMD, 8'h00, 0);
        check({7'h00, hardware_protected_mode}, 8'h01);
        cmd(eeprom_spi_pkg::STATUS_WRITE_CMD, 8'h00, 8);
        rd_status(st);
        check(st, 8'h8e);
        @(posedge sys_clk_i);
        #2 wp_b = 1'b1;
        u_master.select();
        u_master.shift(eeprom_spi_pkg::STATUS_WRITE_CMD, 8, st);
        u_master.shift(8'h00, 8, st);
        u_master.shift(8'h00, 1, st);
        u_master.deselect();
        rd_status(st);
        check(st, 8'h8e);
        cmd(eeprom_spi_pkg::STATUS_WRITE_CMD, 8'h00, 8);
        wait_idle();
        rd_status(st);
        check(st, 8'h00);
        check({7'h00, hardware_protected_mode}, 8'h00);
        u_master.select();
        u_master.shift(8'hff, 8, st);
        u_master.shift(eeprom_spi_pkg::STATUS_READ_CMD, 8, st);
        u_master.shift(8'h00, 8, st);
        check({7'h00, q_oe}, 8'h00);
        u_master.deselect();
        cmd(eeprom_spi_pkg::MEM_READ_CMD, 8'h00, 8);
        check(rd_cnt[7:0], 8'h01);
        mem_write();
        check(wr_cnt[7:0], 8'h00);
        cmd(eeprom_spi_pkg::LATCH_SET_CMD, 8'h00, 0);
        mem_write();
        check(wr_cnt[7:0], 8'h01);
        check({7'h00, busy}, 8'h01);
        cmd(eeprom_spi_pkg::LATCH_CLEAR_CMD, 8'h00, 0);
        check({7'h00, write_enable_latch}, 8'h01);
        wait_idle();
        check({7'h00, write_enable_latch}, 8'h00);
        cmd(eeprom_spi_pkg::LATCH_SET_CMD, 8'h00, 0);
        u_master.select();
        u_master.shift(eeprom_spi_pkg::STATUS_READ_CMD, 8, st);
        u_master.shift(8'h00, 8, st);
        check(st, 8'h02);
        u_master.pause(oe_h);
        check({7'h00, oe_h}, 8'h00);
        u_master.shift(8'h00, 8, s2);
        check(s2, 8'h02);
        u_master.deselect();
        close_out();
    end
endmodule : test_spi_eeprom_command_status_unit

`default_nettype wire
